// *** rtl/dsprc_ctrl_reg.v ***
`include "dsprc_defines.vh"

module dsprc_ctrl_reg (
    // Clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // Write side
    input wire i_wr,
    input wire [7:0] i_data,
    // Stored value
    output reg [7:0] o_q
);

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_q <= `DSPRC_RST_VAL; // [R24]
        end else if (i_wr && (i_data[`DSPRC_LSB] == 1'b0)) begin
            // Byte only lands when written with a zero LSB; otherwise it is dropped
            o_q <= {i_data[7:1], 1'b0}; // [R23]
        end
    end

endmodule

// *** rtl/dsprc_decode.v ***
`include "dsprc_defines.vh"

module dsprc_decode (
    // Control fields
    input wire [1:0] i_bank,
    input wire [1:0] i_ss,
    input wire i_half_mode,
    input wire [1:0] i_wsize,
    // Derived sizes
    output reg [11:0] o_ring_float_words,
    output reg [11:0] o_ring_fixed_words,
    output reg [11:0] o_lin_float_words,
    output reg o_bank_invalid,
    output reg [3:0] o_ss_div,
    output reg [10:0] o_wave_points,
    output reg [9:0] o_wave_words
);

    always @* begin
        o_bank_invalid = 1'b0;
        o_ring_float_words = 12'h000;
        o_ring_fixed_words = 12'h000;
        o_lin_float_words = 12'h000;
        case (i_bank) // [R4]
            2'h0: begin
                o_ring_float_words = `DSPRC_WORDS_3K;
            end
            2'h1: begin
                o_ring_float_words = `DSPRC_WORDS_2K;
                o_ring_fixed_words = `DSPRC_WORDS_2K;
            end
            2'h2: begin
                o_ring_float_words = `DSPRC_WORDS_1K;
                o_ring_fixed_words = `DSPRC_WORDS_2K;
                o_lin_float_words = `DSPRC_WORDS_1K;
            end
            default: begin
                o_bank_invalid = 1'b1;
            end
        endcase
        o_ss_div = 4'h1 << i_ss; // [R5]
        o_wave_points = `DSPRC_WAVE_MIN_PTS << i_wsize; // [R10]
        // Quarter table needs points/4+1 words, half table points/2+1
        if (i_half_mode) begin // [R9]
            o_wave_words = o_wave_points[10:1] + 10'h001;
        end else begin
            o_wave_words = {1'b0, o_wave_points[10:2]} + 10'h001;
        end
    end

endmodule

// *** rtl/dsprc_defines.vh ***
`ifndef DSPRC_DEFINES_VH
`define DSPRC_DEFINES_VH

// Command codes: write C1h-C4h, read 41h-44h
`define DSPRC_CMD_WR_CTRL1 8'hC1
`define DSPRC_CMD_WR_CTRL2 8'hC2
`define DSPRC_CMD_WR_CTRL3 8'hC3
`define DSPRC_CMD_WR_CTRL4 8'hC4
`define DSPRC_CMD_RD_CTRL1 8'h41
`define DSPRC_CMD_RD_CTRL2 8'h42
`define DSPRC_CMD_RD_CTRL3 8'h43
`define DSPRC_CMD_RD_CTRL4 8'h44
`define DSPRC_RST_VAL 8'h00

// Field positions, control register 1
`define DSPRC_C1_MUTE_RAMP 7
`define DSPRC_C1_VOL_STEP 6
`define DSPRC_C1_BANK_HI 5
`define DSPRC_C1_BANK_LO 4
`define DSPRC_C1_SS_HI 2
`define DSPRC_C1_SS_LO 1
// Control register 2
`define DSPRC_C2_PTR0_SRC 7
`define DSPRC_C2_AREA_B_LIN 6
`define DSPRC_C2_SHORT_FRAME 5
`define DSPRC_C2_HALF_MODE 4
`define DSPRC_C2_WSIZE_HI 3
`define DSPRC_C2_WSIZE_LO 2
`define DSPRC_C2_EXT_INSTR 1
// Control register 3
`define DSPRC_C3_DIF_HI 7
`define DSPRC_C3_DIF_LO 6
`define DSPRC_C3_DOF_HI 5
`define DSPRC_C3_DOF_LO 4
`define DSPRC_C3_CLOCK_OUT_FREQ_SEL_HI 3
`define DSPRC_C3_CLOCK_OUT_FREQ_SEL_LO 1
// Control register 4
`define DSPRC_C4_CLOCK_OUT_PIN_ENABLE 7
`define DSPRC_C4_BCK_STOP 6
`define DSPRC_C4_FCK_STOP 5
`define DSPRC_C4_OUT2_DIS 4
`define DSPRC_C4_OUT1_EN 3
`define DSPRC_C4_PIN1_JUMP 2
`define DSPRC_C4_PIN2_JUMP 1
`define DSPRC_LSB 0

// Codes and sizes
`define DSPRC_BANK_INVALID 2'h3
`define DSPRC_CLOCK_OUT_FREQ_SEL_INVALID 3'h7
`define DSPRC_MUTE_RAMP_BASE 12'h390
`define DSPRC_MUTE_RAMP_LONG 12'hE40
`define DSPRC_VOL_STEP_SHORT 3'h1
`define DSPRC_VOL_STEP_LONG 3'h4
`define DSPRC_AREA_A_BASE 11'h000
`define DSPRC_AREA_A_LAST 11'h3FF
`define DSPRC_AREA_B_BASE 11'h400
`define DSPRC_AREA_B_LAST 11'h5FF
`define DSPRC_BITCLK_64 7'h40
`define DSPRC_BITCLK_32 7'h20
`define DSPRC_CKM_SHORT_ONLY 3'h4
`define DSPRC_WORDS_3K 12'hC00
`define DSPRC_WORDS_2K 12'h800
`define DSPRC_WORDS_1K 12'h400
`define DSPRC_WAVE_MIN_PTS 11'h080

`endif

// *** rtl/dsprc_top.v ***
// Notes on behaviour
// [R1] Host writes these registers only while the system is held in reset.
// [R2] Mute ramp bit: 912 frame clocks at 0, four times that at 1.
// [R3] Volume step bit: one sample period at 0, four at 1.
// [R4] Bank field sets delay memory partition; code 11 invalid.
// [R5] Delay address advances every 1, 2, 4 or 8 samples.
// [R6] Pointer zero from offset register at 0, internal data bus at 1.
// [R7] Data area A ring with pointer zero; area B ring or linear by bit.
// [R8] Bit clock 64 or 32 per frame, slave only; mode 4 needs 32.
// [R9] Wave mode: quarter-period table at 0, half-period at 1.
// [R10] Wave size selects 128 to 1024 points and matching word counts.
// [R11] Extended instruction set enabled when bit is 1.
// [R12] Input format: MSB 24, LSB 24, LSB 20, LSB 16.
// [R13] Output format: MSB 24, LSB 24, LSB 20, LSB 16.
// [R14] Host keeps output format zero with Philips framing or short frame.
// [R15] Clock output select picks the frequency; code 111 invalid.
// [R16] Clock output pin driven only when its enable bit is 1.
// [R17] In master mode, stop bits force bit or frame clock low.
// [R18] In slave modes the other party supplies bit and frame clocks.
// [R19] Shared output pin driven at 0, disabled at 1.
// [R20] First serial output pin disabled at 0, driven at 1.
// [R21] Pin one goes to serial input one or jump input one.
// [R22] Pin two goes to serial input two or zero jump input.
// [R23] A register byte takes effect only when written with zero LSB.
// [R24] Only the hardware reset restores defaults; system reset keeps them.
// [R25] While the run bit is 0, converters and DSP are held in reset.
`include "dsprc_defines.vh"

module dsprc_top (
    // Clock and hardware reset
    input wire i_clk,
    input wire i_rst_n,
    // Command port from the microcontroller interface
    input wire i_cmd_valid,
    input wire [7:0] i_cmd_code,
    input wire [7:0] i_cmd_wdata,
    output reg [7:0] o_cmd_rdata,
    output reg o_cmd_rvalid,
    output wire o_cmd_error,
    // System state
    input wire i_system_run_bit,
    input wire i_master_mode,
    input wire [2:0] i_clocking_mode,
    input wire i_philips_framing_select,
    output wire o_core_reset,
    output wire o_config_warning,
    // Audio and delay timing
    output reg [11:0] o_adc_mute_ramp_len,
    output reg [2:0] o_dac_volume_step_time,
    output wire [1:0] o_delay_bank,
    output wire o_delay_bank_invalid,
    output wire [11:0] o_ring_float_words,
    output wire [11:0] o_ring_fixed_words,
    output wire [11:0] o_lin_float_words,
    output wire [3:0] o_delay_addr_every,
    // Memory addressing
    output wire o_delay_ptr0_source,
    input wire [10:0] i_offset_register,
    input wire [10:0] i_internal_data_bus,
    output reg [10:0] o_data_pointer_zero,
    input wire [10:0] i_data_addr,
    output reg o_data_area_b,
    output reg o_data_area_b_linear_now,
    output wire o_data_mem_area_b_linear,
    // Waveform table and instruction set
    output wire o_wave_table_half_mode,
    output wire [1:0] o_wave_table_size,
    output wire [10:0] o_wave_points,
    output wire [9:0] o_wave_words,
    output wire o_ext_instr_enable,
    // Serial formats and clocks
    output wire [1:0] o_input_word_format,
    output wire [1:0] o_output_word_format,
    output wire o_short_frame_bitclk,
    output reg [6:0] o_bitclk_per_frame,
    output wire [2:0] o_clock_out_freq_sel,
    output wire o_clock_out_sel_invalid,
    // Clock pins
    input wire i_clock_out_src,
    output reg o_clock_output_pin,
    output wire o_clock_output_pin_oe,
    input wire i_bit_clock_gen,
    input wire i_frame_clock_gen,
    output reg o_bit_clock,
    output reg o_frame_clock,
    output wire o_bit_clock_oe,
    output wire o_frame_clock_oe,
    // Serial output pins
    input wire i_shared_out_data,
    input wire i_first_out_data,
    output reg o_shared_out,
    output wire o_shared_out_oe,
    output reg o_first_serial_output,
    output wire o_first_serial_output_oe,
    // Shared input pins
    input wire i_first_serial_input_pin,
    input wire i_second_serial_input_pin,
    output reg o_first_serial_input,
    output reg o_jump1_input,
    output reg o_second_serial_input,
    output reg o_jump0_input
);

    wire [7:0] ctrl1_q;
    wire [7:0] ctrl2_q;
    wire [7:0] ctrl3_q;
    wire [7:0] ctrl4_q;
    reg wr1;
    reg wr2;
    reg wr3;
    reg wr4;
    reg cmd_known;
    reg [7:0] rd_nxt;
    reg rd_hit;
    wire [3:0] ss_div;
    wire bank_bad;

    // Command decode
    always @* begin
        wr1 = 1'b0;
        wr2 = 1'b0;
        wr3 = 1'b0;
        wr4 = 1'b0;
        rd_hit = 1'b0;
        rd_nxt = 8'h00;
        cmd_known = 1'b1;
        case (i_cmd_code)
            `DSPRC_CMD_WR_CTRL1: wr1 = i_cmd_valid;
            `DSPRC_CMD_WR_CTRL2: wr2 = i_cmd_valid;
            `DSPRC_CMD_WR_CTRL3: wr3 = i_cmd_valid;
            `DSPRC_CMD_WR_CTRL4: wr4 = i_cmd_valid;
            `DSPRC_CMD_RD_CTRL1: begin
                rd_hit = i_cmd_valid;
                rd_nxt = ctrl1_q;
            end
            `DSPRC_CMD_RD_CTRL2: begin
                rd_hit = i_cmd_valid;
                rd_nxt = ctrl2_q;
            end
            `DSPRC_CMD_RD_CTRL3: begin
                rd_hit = i_cmd_valid;
                rd_nxt = ctrl3_q;
            end
            `DSPRC_CMD_RD_CTRL4: begin
                rd_hit = i_cmd_valid;
                rd_nxt = ctrl4_q;
            end
            default: cmd_known = 1'b0;
        endcase
    end

    // Unknown codes are flagged, never stored
    assign o_cmd_error = i_cmd_valid && !cmd_known;

    dsprc_ctrl_reg u_ctrl1 (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_wr(wr1),
        .i_data(i_cmd_wdata),
        .o_q(ctrl1_q)
    );
    dsprc_ctrl_reg u_ctrl2 (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_wr(wr2),
        .i_data(i_cmd_wdata),
        .o_q(ctrl2_q)
    );
    dsprc_ctrl_reg u_ctrl3 (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_wr(wr3),
        .i_data(i_cmd_wdata),
        .o_q(ctrl3_q)
    );
    dsprc_ctrl_reg u_ctrl4 (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_wr(wr4),
        .i_data(i_cmd_wdata),
        .o_q(ctrl4_q)
    );

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_cmd_rdata <= 8'h00;
            o_cmd_rvalid <= 1'b0;
        end else begin
            o_cmd_rvalid <= rd_hit;
            if (rd_hit) begin
                o_cmd_rdata <= rd_nxt;
            end
        end
    end

    // Run bit lives elsewhere; it holds the core but never clears us
    assign o_core_reset = !i_system_run_bit; // [R25]

    // Writes while running still land; this flag lets software spot it
    reg cfg_warn_r;
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            cfg_warn_r <= 1'b0;
        end else begin
            cfg_warn_r <= (i_system_run_bit && (wr1 || wr2 || wr3 || wr4)) // [R1]
                || (i_clocking_mode == `DSPRC_CKM_SHORT_ONLY && !o_short_frame_bitclk) // [R8]
                || ((i_philips_framing_select || o_short_frame_bitclk)
                    && o_output_word_format != 2'h0); // [R14]
        end
    end
    assign o_config_warning = cfg_warn_r;

    dsprc_decode u_decode (
        .i_bank(ctrl1_q[`DSPRC_C1_BANK_HI:`DSPRC_C1_BANK_LO]),
        .i_ss(ctrl1_q[`DSPRC_C1_SS_HI:`DSPRC_C1_SS_LO]),
        .i_half_mode(o_wave_table_half_mode),
        .i_wsize(o_wave_table_size),
        .o_ring_float_words(o_ring_float_words),
        .o_ring_fixed_words(o_ring_fixed_words),
        .o_lin_float_words(o_lin_float_words),
        .o_bank_invalid(bank_bad),
        .o_ss_div(ss_div),
        .o_wave_points(o_wave_points),
        .o_wave_words(o_wave_words)
    );

    assign o_delay_bank = ctrl1_q[`DSPRC_C1_BANK_HI:`DSPRC_C1_BANK_LO];
    assign o_delay_bank_invalid = bank_bad; // [R4]
    assign o_delay_addr_every = ss_div; // [R5]
    assign o_delay_ptr0_source = ctrl2_q[`DSPRC_C2_PTR0_SRC];
    assign o_data_mem_area_b_linear = ctrl2_q[`DSPRC_C2_AREA_B_LIN];
    assign o_short_frame_bitclk = ctrl2_q[`DSPRC_C2_SHORT_FRAME];
    assign o_wave_table_half_mode = ctrl2_q[`DSPRC_C2_HALF_MODE];
    assign o_wave_table_size = ctrl2_q[`DSPRC_C2_WSIZE_HI:`DSPRC_C2_WSIZE_LO];
    assign o_ext_instr_enable = ctrl2_q[`DSPRC_C2_EXT_INSTR]; // [R11]
    assign o_input_word_format = ctrl3_q[`DSPRC_C3_DIF_HI:`DSPRC_C3_DIF_LO]; // [R12]
    assign o_output_word_format = ctrl3_q[`DSPRC_C3_DOF_HI:`DSPRC_C3_DOF_LO]; // [R13]
    assign o_clock_out_freq_sel = ctrl3_q[`DSPRC_C3_CLOCK_OUT_FREQ_SEL_HI:`DSPRC_C3_CLOCK_OUT_FREQ_SEL_LO]; // [R15]
    assign o_clock_out_sel_invalid = (o_clock_out_freq_sel == `DSPRC_CLOCK_OUT_FREQ_SEL_INVALID); // [R15]

    // Pin enables; invalid clock code keeps the pin quiet
    assign o_clock_output_pin_oe = ctrl4_q[`DSPRC_C4_CLOCK_OUT_PIN_ENABLE] && !o_clock_out_sel_invalid; // [R16]
    assign o_shared_out_oe = !ctrl4_q[`DSPRC_C4_OUT2_DIS]; // [R19]
    assign o_first_serial_output_oe = ctrl4_q[`DSPRC_C4_OUT1_EN]; // [R20]
    // Slave modes: the other party drives both clocks
    assign o_bit_clock_oe = i_master_mode; // [R18]
    assign o_frame_clock_oe = i_master_mode; // [R18]

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_adc_mute_ramp_len <= `DSPRC_MUTE_RAMP_BASE;
            o_dac_volume_step_time <= `DSPRC_VOL_STEP_SHORT;
            o_data_pointer_zero <= 11'h000;
            o_data_area_b <= 1'b0;
            o_data_area_b_linear_now <= 1'b0;
            o_bitclk_per_frame <= `DSPRC_BITCLK_64;
            o_clock_output_pin <= 1'b0;
            o_bit_clock <= 1'b0;
            o_frame_clock <= 1'b0;
            o_shared_out <= 1'b0;
            o_first_serial_output <= 1'b0;
            o_first_serial_input <= 1'b0;
            o_jump1_input <= 1'b0;
            o_second_serial_input <= 1'b0;
            o_jump0_input <= 1'b0;
        end else begin
            o_adc_mute_ramp_len <= ctrl1_q[`DSPRC_C1_MUTE_RAMP] ?
                `DSPRC_MUTE_RAMP_LONG : `DSPRC_MUTE_RAMP_BASE; // [R2]
            o_dac_volume_step_time <= ctrl1_q[`DSPRC_C1_VOL_STEP] ?
                `DSPRC_VOL_STEP_LONG : `DSPRC_VOL_STEP_SHORT; // [R3]
            o_data_pointer_zero <= o_delay_ptr0_source ?
                i_internal_data_bus : i_offset_register; // [R6]
            // Area B spans 400h-5FFh; area A is always ring
            o_data_area_b <= (i_data_addr >= `DSPRC_AREA_B_BASE) && (i_data_addr <= `DSPRC_AREA_B_LAST); // [R7]
            o_data_area_b_linear_now <= (i_data_addr >= `DSPRC_AREA_B_BASE)
                && (i_data_addr <= `DSPRC_AREA_B_LAST) && o_data_mem_area_b_linear; // [R7]
            // Short frame only meaningful in slave operation
            o_bitclk_per_frame <= (o_short_frame_bitclk && !i_master_mode) ?
                `DSPRC_BITCLK_32 : `DSPRC_BITCLK_64; // [R8]
            o_clock_output_pin <= o_clock_output_pin_oe && i_clock_out_src; // [R16]
            o_bit_clock <= i_bit_clock_gen && !(i_master_mode && ctrl4_q[`DSPRC_C4_BCK_STOP]); // [R17]
            o_frame_clock <= i_frame_clock_gen && !(i_master_mode && ctrl4_q[`DSPRC_C4_FCK_STOP]); // [R17]
            o_shared_out <= i_shared_out_data;
            o_first_serial_output <= i_first_out_data;
            if (ctrl4_q[`DSPRC_C4_PIN1_JUMP]) begin // [R21]
                o_first_serial_input <= 1'b0;
                o_jump1_input <= i_first_serial_input_pin;
            end else begin
                o_first_serial_input <= i_first_serial_input_pin;
                o_jump1_input <= 1'b0;
            end
            if (ctrl4_q[`DSPRC_C4_PIN2_JUMP]) begin // [R22]
                o_second_serial_input <= 1'b0;
                o_jump0_input <= i_second_serial_input_pin;
            end else begin
                o_second_serial_input <= i_second_serial_input_pin;
                o_jump0_input <= 1'b0;
            end
        end
    end

endmodule

// *** tb/dsprc_monitor.sv ***
module dsprc_monitor (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Command port
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd_code,
    input wire logic [7:0] i_cmd_wdata,
    // System state
    input wire logic i_system_run_bit,
    input wire logic i_master_mode,
    input wire logic o_core_reset,
    // Fields and pins
    input wire logic [11:0] o_adc_mute_ramp_len,
    input wire logic [2:0] o_dac_volume_step_time,
    input wire logic o_delay_ptr0_source,
    input wire logic [10:0] i_internal_data_bus,
    input wire logic [10:0] o_data_pointer_zero,
    input wire logic o_short_frame_bitclk,
    input wire logic [6:0] o_bitclk_per_frame,
    input wire logic o_clock_out_sel_invalid,
    input wire logic o_clock_output_pin_oe,
    input wire logic o_bit_clock,
    input wire logic o_frame_clock,
    input wire logic o_shared_out_oe,
    input wire logic o_first_serial_output_oe
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    wire c1_wr = i_cmd_valid && i_cmd_code == 8'hC1 && !i_cmd_wdata[0];
    wire c4_wr = i_cmd_valid && i_cmd_code == 8'hC4 && !i_cmd_wdata[0];

    a_lsb_write_guard:
    assert property (i_cmd_valid && i_cmd_code == 8'hC1 && i_cmd_wdata[0]
        |-> ##2 $stable(o_adc_mute_ramp_len) && $stable(o_dac_volume_step_time))
        else $error("odd byte took effect");
    a_ramp_long_set:
    assert property (c1_wr && i_cmd_wdata[7:6] == 2'b10
        |-> ##2 o_adc_mute_ramp_len == 12'hE40 && o_dac_volume_step_time == 3'h1) else $error("long ramp wrong");
    a_step_long_set:
    assert property (c1_wr && i_cmd_wdata[7:6] == 2'b01
        |-> ##2 o_adc_mute_ramp_len == 12'h390 && o_dac_volume_step_time == 3'h4) else $error("long step wrong");
    a_bitclk_short_slave:
    assert property (!i_master_mode && o_short_frame_bitclk |=> o_bitclk_per_frame == 7'h20)
        else $error("short frame count wrong");
    a_bitclk_master_full:
    assert property (i_master_mode |=> o_bitclk_per_frame == 7'h40) else $error("master frame count wrong");
    a_ptr0_from_bus:
    assert property (o_delay_ptr0_source |=> o_data_pointer_zero == $past(i_internal_data_bus))
        else $error("pointer zero not from bus");
    a_clkout_invalid_off:
    assert property (o_clock_out_sel_invalid |-> !o_clock_output_pin_oe) else $error("clock pin on invalid code");
    a_core_reset_hold:
    assert property (o_core_reset == !i_system_run_bit) else $error("core reset wrong");
    a_master_clocks_stop:
    assert property (c4_wr && i_cmd_wdata[6:5] == 2'b11 ##1 i_master_mode [*2]
        |-> !o_bit_clock && !o_frame_clock) else $error("clocks not stopped");
    a_outputs_disabled:
    assert property (c4_wr && i_cmd_wdata[4:3] == 2'b10
        |=> !o_shared_out_oe && !o_first_serial_output_oe) else $error("output enables wrong");
endmodule

bind dsprc_top dsprc_monitor u_mon (.*);

// *** tb/tb.sv ***
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_cmd_valid = 1'b0, i_system_run_bit = 1'b0;
    logic i_master_mode = 1'b0, i_philips_framing_select = 1'b0, i_clock_out_src = 1'b1;
    logic i_bit_clock_gen = 1'b1, i_frame_clock_gen = 1'b1, i_shared_out_data = 1'b1;
    logic i_first_out_data = 1'b1, i_first_serial_input_pin = 1'b1, i_second_serial_input_pin = 1'b1;
    logic [7:0] i_cmd_code = 8'h00, i_cmd_wdata = 8'h00, d;
    logic [2:0] i_clocking_mode = 3'h0;
    logic [10:0] i_offset_register = 11'h0A5, i_internal_data_bus = 11'h35A, i_data_addr = 11'h000;
    logic [1:0] v;
    logic [7:0] t4 [3] = '{8'h70, 8'h4A, 8'h1E};
    wire [11:0] o_adc_mute_ramp_len, o_ring_float_words, o_ring_fixed_words, o_lin_float_words;
    wire [10:0] o_data_pointer_zero, o_wave_points;
    wire [9:0] o_wave_words;
    wire [7:0] o_cmd_rdata;
    wire [6:0] o_bitclk_per_frame;
    wire [3:0] o_delay_addr_every;
    wire [2:0] o_dac_volume_step_time, o_clock_out_freq_sel;
    wire [1:0] o_input_word_format, o_output_word_format, o_delay_bank, o_wave_table_size;
    wire o_cmd_rvalid, o_cmd_error, o_core_reset, o_delay_bank_invalid, o_data_area_b_linear_now;
    wire o_ext_instr_enable, o_clock_output_pin_oe, o_clock_out_sel_invalid, o_bit_clock, o_frame_clock;
    wire o_shared_out_oe, o_first_serial_output_oe, o_first_serial_input, o_jump1_input;
    wire o_second_serial_input, o_jump0_input, o_config_warning, o_data_area_b, o_delay_ptr0_source;
    wire o_data_mem_area_b_linear, o_short_frame_bitclk, o_wave_table_half_mode, o_bit_clock_oe;
    wire o_frame_clock_oe, o_clock_output_pin, o_shared_out, o_first_serial_output;
    int n_fail = 0, samples_checked = 0, i;

    dsprc_top uut (
        .i_clk, .i_rst_n, .i_cmd_valid, .i_cmd_code, .i_cmd_wdata, .o_cmd_rdata, .o_cmd_rvalid, .o_cmd_error,
        .i_system_run_bit, .i_master_mode, .i_clocking_mode, .i_philips_framing_select, .o_core_reset,
        .o_config_warning, .o_adc_mute_ramp_len, .o_dac_volume_step_time, .o_delay_bank,
        .o_delay_bank_invalid, .o_ring_float_words, .o_ring_fixed_words, .o_lin_float_words,
        .o_delay_addr_every, .o_delay_ptr0_source, .i_offset_register, .i_internal_data_bus,
        .o_data_pointer_zero, .i_data_addr, .o_data_area_b, .o_data_area_b_linear_now,
        .o_data_mem_area_b_linear, .o_wave_table_half_mode, .o_wave_table_size, .o_wave_points,
        .o_wave_words, .o_ext_instr_enable, .o_input_word_format, .o_output_word_format,
        .o_short_frame_bitclk, .o_bitclk_per_frame, .o_clock_out_freq_sel, .o_clock_out_sel_invalid,
        .i_clock_out_src, .o_clock_output_pin, .o_clock_output_pin_oe, .i_bit_clock_gen,
        .i_frame_clock_gen, .o_bit_clock, .o_frame_clock, .o_bit_clock_oe, .o_frame_clock_oe,
        .i_shared_out_data, .i_first_out_data, .o_shared_out, .o_shared_out_oe, .o_first_serial_output,
        .o_first_serial_output_oe, .i_first_serial_input_pin, .i_second_serial_input_pin,
        .o_first_serial_input, .o_jump1_input, .o_second_serial_input, .o_jump0_input
    );

    initial begin
        forever #25 i_clk = ~i_clk;
    end

    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    // Fields settle one edge after the command is taken
    task automatic wr(input [7:0] c, input [7:0] w);
        @(posedge i_clk);
        i_cmd_valid <= 1'b1;
        i_cmd_code <= c;
        i_cmd_wdata <= w;
        @(posedge i_clk);
        i_cmd_valid <= 1'b0;
        @(posedge i_clk);
        #1;
    endtask

    task automatic rd(input [7:0] c, input [7:0] e);
        @(posedge i_clk);
        i_cmd_valid <= 1'b1;
        i_cmd_code <= c;
        @(posedge i_clk);
        i_cmd_valid <= 1'b0;
        #1;
        chk("rvalid", 12'h1, o_cmd_rvalid);
        chk("rdata", e, o_cmd_rdata);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #100000;
        n_fail++;
        tally_and_finish();
    end

    initial begin
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        for (i = 0; i < 4; i++) rd(8'h41 + i, 8'h00);
        chk("ramp", 12'h390, o_adc_mute_ramp_len);
        chk("core", 12'h1, o_core_reset);
        wr(8'hC1, 8'hF7);
        rd(8'h41, 8'h00);
        for (i = 0; i < 4; i++) begin
            v = i[1:0];
            d = {v, v, 1'b0, v, 1'b0};
            wr(8'hC1, d);
            chk("ramp", v[1] ? 12'hE40 : 12'h390, o_adc_mute_ramp_len);
            chk("step", v[0] ? 12'h4 : 12'h1, o_dac_volume_step_time);
            chk("bad", v == 2'h3, o_delay_bank_invalid);
            chk("bank", v, o_delay_bank);
            if (v != 2'h3) begin
                chk("float", 12'hC00 - {v, 10'h0}, o_ring_float_words);
                chk("fixed", v == 2'h0 ? 12'h0 : 12'h800, o_ring_fixed_words);
                chk("lin", v == 2'h2 ? 12'h400 : 12'h0, o_lin_float_words);
            end
            chk("every", 12'h1 << v, o_delay_addr_every);
            rd(8'h41, d);
        end
        for (i = 0; i < 4; i++) begin
            v = i[1:0];
            d = {v[0], v[0], 1'b0, v[1], v, v[0], 1'b0};
            @(posedge i_clk);
            // Walks both area ends and one address past area B
            i_data_addr <= v[1] ? (v[0] ? 11'h600 : 11'h5FF) : (v[0] ? 11'h400 : 11'h3FF);
            i_internal_data_bus <= {v, 9'h15A};
            i_offset_register <= {~v, 9'h0A5};
            wr(8'hC2, d);
            chk("ptr0", v[0] ? {v, 9'h15A} : {~v, 9'h0A5}, o_data_pointer_zero);
            chk("areab", v == 2'h1, o_data_area_b_linear_now);
            chk("inb", v[1] ^ v[0], o_data_area_b);
            chk("linbit", v[0], o_data_mem_area_b_linear);
            chk("src", v[0], o_delay_ptr0_source);
            chk("half", v[1], o_wave_table_half_mode);
            chk("wsize", v, o_wave_table_size);
            chk("points", 12'h80 << v, o_wave_points);
            chk("words", (12'h20 << v << d[4]) + 12'h1, o_wave_words);
            chk("ext", v[0], o_ext_instr_enable);
        end
        wr(8'hC4, 8'h80);
        for (i = 0; i < 8; i++) begin
            v = i[1:0];
            wr(8'hC3, {v, v, i[2:0], 1'b0});
            chk("infmt", v, o_input_word_format);
            chk("outfmt", v, o_output_word_format);
            chk("clock_out_pin_enable", i != 7, o_clock_output_pin_oe);
            chk("clkbad", i == 7, o_clock_out_sel_invalid);
            chk("clock_out_freq_sel", i[2:0], o_clock_out_freq_sel);
            chk("clkpin", i != 7, o_clock_output_pin);
        end
        wr(8'hC3, 8'h00);
        wr(8'hC2, 8'h20);
        @(posedge i_clk);
        i_clocking_mode <= 3'h4;
        #1;
        chk("bclk32", 12'h20, o_bitclk_per_frame);
        chk("short", 12'h1, o_short_frame_bitclk);
        // Master operation only in clock mode 0
        @(posedge i_clk);
        i_master_mode <= 1'b1;
        i_clocking_mode <= 3'h0;
        repeat (2) @(posedge i_clk);
        #1;
        chk("bclk64", 12'h40, o_bitclk_per_frame);
        chk("bckoe", 12'h1, o_bit_clock_oe);
        chk("fckoe", 12'h1, o_frame_clock_oe);
        for (i = 0; i < 3; i++) begin
            d = t4[i];
            wr(8'hC4, d);
            chk("bck", !d[6], o_bit_clock);
            chk("fck", !d[5], o_frame_clock);
            chk("shoe", !d[4], o_shared_out_oe);
            chk("s1oe", d[3], o_first_serial_output_oe);
            chk("jmp1", d[2], o_jump1_input);
            chk("sin1", !d[2], o_first_serial_input);
            chk("jmp0", d[1], o_jump0_input);
            chk("sin2", !d[1], o_second_serial_input);
            chk("sho", 12'h1, o_shared_out);
            chk("s1o", 12'h1, o_first_serial_output);
        end
        chk("warn", 12'h0, o_config_warning);
        @(posedge i_clk);
        i_system_run_bit <= 1'b1;
        i_cmd_valid <= 1'b1;
        i_cmd_code <= 8'hC5;
        #1;
        chk("err", 12'h1, o_cmd_error);
        chk("core", 12'h0, o_core_reset);
        @(posedge i_clk);
        i_cmd_valid <= 1'b0;
        rd(8'h44, 8'h1E);
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(8'h44, 8'h00);
        tally_and_finish();
    end
endmodule
